// File: include/rzpg_pkg.sv
// Constants and register map for the ramp and home-return pulse block.
// Assumes a single 10 MHz clock and an AXI4-Lite register master.

package rzpg_pkg;

  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [5:0] IDX_FREQ_RANGE = 6'h00;
  localparam logic [5:0] IDX_STEADY = 6'h01;
  localparam logic [5:0] IDX_INITIAL = 6'h02;
  localparam logic [5:0] IDX_CHANGE_TIME = 6'h03;
  localparam logic [5:0] IDX_REV_EN = 6'h04;
  localparam logic [5:0] IDX_DIR = 6'h05;
  localparam logic [5:0] IDX_PRESET_HI = 6'h06;
  localparam logic [5:0] IDX_PRESET_LO = 6'h07;
  localparam logic [5:0] IDX_CUR_HI = 6'h08;
  localparam logic [5:0] IDX_CUR_LO = 6'h09;
  localparam logic [5:0] IDX_ERROR = 6'h0a;
  localparam logic [5:0] IDX_STATUS = 6'h0b;
  localparam logic [5:0] IDX_HR_MODE = 6'h0c;
  localparam logic [5:0] IDX_HR_HIGH = 6'h0d;
  localparam logic [5:0] IDX_HR_CREEP_MODE = 6'h0e;
  localparam logic [5:0] IDX_HR_CREEP = 6'h0f;
  localparam logic [5:0] IDX_HR_CTRL = 6'h10;

  // Status register bit positions
  localparam int ST_ACTIVE = 0;
  localparam int ST_DONE = 1;
  localparam int ST_TRANS = 2;
  localparam int ST_OVF = 3;
  localparam int ST_HR_BUSY = 4;

  // Frequency ranges and reversible modes
  localparam logic [15:0] MODE_200HZ_100K = 16'h0003;
  localparam logic [15:0] MODE_1K_100K = 16'h0002;
  localparam logic [15:0] MODE_100_10K = 16'h0001;
  localparam logic [15:0] MODE_10_1K = 16'h0000;
  localparam logic [15:0] REV_NONE = 16'h0000;
  localparam logic [15:0] REV_SINGLE = 16'h0001;
  localparam logic [15:0] REV_DUAL = 16'h0002;

  // Error codes
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_MODE = 16'h0001;
  localparam logic [15:0] ERR_FREQ = 16'h0002;

  // Timing: clock in Hz, change time unit 1 ms
  localparam int CLK_HZ = 10_000_000;
  localparam int MS_PER_S = 1000;
  localparam logic [31:0] CYC_PER_MS = 32'(CLK_HZ / MS_PER_S);
  // Frequency held in 10 Hz units internally (max 10000)
  localparam int HZ_UNIT = 10;
  localparam logic [31:0] CLK_UNITS = 32'(CLK_HZ / HZ_UNIT);
  // 100 kHz max range in 10 Hz units, 1 % of it, etc.
  localparam logic [15:0] F_MAX_10K = 16'h0064;  // 1 kHz / 10 Hz units
  localparam logic [15:0] F_MIN_M3 = 16'h0014;   // 20 units = 200 Hz
  localparam logic [15:0] F_MAX_M3 = 16'h2710;   // 10000 units = 100 kHz
  localparam logic [15:0] PCT_MAX = 16'h0064;    // 100 percent

  // Reset values
  localparam logic [15:0] RST_WORD = 16'h0000;

endpackage : rzpg_pkg

// File: src/rzpg_top.sv
// Ramped pulse generator with home-return channels and AXI4-Lite registers.
// Assumes start, deceleration and home-return inputs are synchronous levels.
`timescale 1ns/1ps

module rzpg_top #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic start_in,
  input wire logic decel_in,
  input wire logic home_start_in,
  input wire logic [2:0] gpio_out,
  output logic pulse_out_a,
  output logic pulse_out_b,
  output logic pulse_out_c
);

  // Byte address bits 7:2 carry the register index
  if (ADDR_W < 8) begin : g_addr_chk
    $error("ADDR_W too small for register map");
  end

  typedef enum logic [1:0] {RZ_IDLE, RZ_RAMP, RZ_STEADY} rzpg_rst_t;
  typedef enum logic [1:0] {HR_IDLE, HR_FAST, HR_CREEP, HR_DONE} rzpg_hr_t;

  typedef struct packed {
    logic aw_hold;
    logic w_hold;
    logic [5:0] aw_idx;
    logic [31:0] wdata;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [15:0] range_sel;
    logic [15:0] steady;
    logic [15:0] initial_f;
    logic [15:0] change_ms;
    logic [15:0] rev_en;
    logic [15:0] dir;
    logic [15:0] preset_hi;
    logic [15:0] preset_lo;
    logic [15:0] err;
    logic [15:0] hr_mode;
    logic [15:0] hr_high;
    logic [15:0] hr_cmode;
    logic [15:0] hr_creep;
    logic [1:0] hr_chan;
    logic rev_live;
    logic rev_taken;
    rzpg_rst_t st;
    logic [15:0] f_cur;
    logic [15:0] f_tgt;
    logic [31:0] slope_cnt;
    logic [31:0] slope_per;
    logic [31:0] preset;
    logic [31:0] count;
    logic [31:0] phase;
    logic pulse;
    logic lane_b;
    logic dir_lvl;
    logic rev_mode_sel;
    logic start_q;
    logic active;
    logic done;
    logic trans;
    logic ovf;
    rzpg_hr_t hr;
    logic hr_q;
    logic [15:0] hr_f;
    logic [31:0] hr_phase;
    logic hr_lvl;
  } rzpg_state_t;

  rzpg_state_t r;
  rzpg_state_t next_r;

  // Convert a range and parameter into 10 Hz units, 0 when invalid
  function automatic logic [15:0] to_units(input logic [15:0] mode,
                                           input logic [15:0] val);
    logic [31:0] scaled;
    scaled = 32'h0;
    to_units = 16'h0;
    if (mode == rzpg_pkg::MODE_200HZ_100K) begin
      if (val >= rzpg_pkg::F_MIN_M3 && val <= rzpg_pkg::F_MAX_M3)
        to_units = val;
    end else if (mode <= rzpg_pkg::MODE_1K_100K) begin
      if (val != 16'h0 && val <= rzpg_pkg::PCT_MAX) begin
        // Range max in 10 Hz units is 100, 1000 or 10000
        scaled = 32'(val) * ((mode == rzpg_pkg::MODE_1K_100K) ? 32'd100 :
                 (mode == rzpg_pkg::MODE_100_10K) ? 32'd10 : 32'd1);
        to_units = scaled[15:0];
      end
    end
  endfunction : to_units

  // Half-period in clocks for a frequency in 10 Hz units
  function automatic logic [31:0] half_per(input logic [15:0] f);
    half_per = (f == 16'h0) ? 32'hffff_ffff :
               rzpg_pkg::CLK_UNITS / (32'(f) << 1);
  endfunction : half_per

  // Register read mux
  function automatic logic [15:0] rd_word(input rzpg_state_t s,
                                          input logic [5:0] i);
    case (i)
      rzpg_pkg::IDX_FREQ_RANGE: rd_word = s.range_sel;
      rzpg_pkg::IDX_STEADY: rd_word = s.steady;
      rzpg_pkg::IDX_INITIAL: rd_word = s.initial_f;
      rzpg_pkg::IDX_CHANGE_TIME: rd_word = s.change_ms;
      rzpg_pkg::IDX_REV_EN: rd_word = s.rev_en;
      rzpg_pkg::IDX_DIR: rd_word = s.dir;
      rzpg_pkg::IDX_PRESET_HI: rd_word = s.preset_hi;
      rzpg_pkg::IDX_PRESET_LO: rd_word = s.preset_lo;
      rzpg_pkg::IDX_CUR_HI: rd_word = s.count[31:16];
      rzpg_pkg::IDX_CUR_LO: rd_word = s.count[15:0];
      rzpg_pkg::IDX_ERROR: rd_word = s.err;
      rzpg_pkg::IDX_STATUS: begin
        rd_word = 16'h0;
        rd_word[rzpg_pkg::ST_ACTIVE] = s.active;
        rd_word[rzpg_pkg::ST_DONE] = s.done;
        rd_word[rzpg_pkg::ST_TRANS] = s.trans;
        rd_word[rzpg_pkg::ST_OVF] = s.ovf;
        rd_word[rzpg_pkg::ST_HR_BUSY] = (s.hr != HR_IDLE);
      end
      rzpg_pkg::IDX_HR_MODE: rd_word = s.hr_mode;
      rzpg_pkg::IDX_HR_HIGH: rd_word = s.hr_high;
      rzpg_pkg::IDX_HR_CREEP_MODE: rd_word = s.hr_cmode;
      rzpg_pkg::IDX_HR_CREEP: rd_word = s.hr_creep;
      rzpg_pkg::IDX_HR_CTRL: rd_word = {14'h0, s.hr_chan};
      default: rd_word = 16'h0;
    endcase
  endfunction : rd_word

  // -----------------------------------------------------------------
  // Next-state logic
  // -----------------------------------------------------------------
  always_comb begin
    logic wr_go;
    logic [15:0] wd;
    logic [15:0] f_ini;
    logic [15:0] f_st;
    logic [31:0] ramp_t;
    logic [31:0] df;
    logic edge_tick;
    logic [15:0] hf;
    logic [15:0] cf;
    wr_go = 1'b0;
    wd = 16'h0;
    f_ini = 16'h0;
    f_st = 16'h0;
    ramp_t = 32'h0;
    df = 32'h0;
    edge_tick = 1'b0;
    hf = 16'h0;
    cf = 16'h0;
    next_r = r;

    // Bus: address and data taken in either order, then one response
    if (s_axi_awvalid && s_axi_awready) begin
      next_r.aw_hold = 1'b1;
      next_r.aw_idx = s_axi_awaddr[7:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_r.w_hold = 1'b1;
      next_r.wdata = s_axi_wdata;
    end
    if (r.aw_hold && r.w_hold && !r.bvalid) begin
      wr_go = 1'b1;
      wd = r.wdata[15:0];
      next_r.aw_hold = 1'b0;
      next_r.w_hold = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = (r.aw_idx > rzpg_pkg::IDX_HR_CTRL) ? 2'b10 : 2'b00;
    end
    if (r.bvalid && s_axi_bready)
      next_r.bvalid = 1'b0;
    if (wr_go) begin
      case (r.aw_idx)
        rzpg_pkg::IDX_FREQ_RANGE: next_r.range_sel = wd;
        rzpg_pkg::IDX_STEADY: next_r.steady = wd;
        rzpg_pkg::IDX_INITIAL: next_r.initial_f = wd;
        rzpg_pkg::IDX_CHANGE_TIME: next_r.change_ms = wd;
        rzpg_pkg::IDX_REV_EN: next_r.rev_en = wd;
        rzpg_pkg::IDX_DIR: next_r.dir = wd;
        rzpg_pkg::IDX_PRESET_HI: next_r.preset_hi = wd;
        rzpg_pkg::IDX_PRESET_LO: next_r.preset_lo = wd;
        rzpg_pkg::IDX_HR_MODE: next_r.hr_mode = wd;
        rzpg_pkg::IDX_HR_HIGH: next_r.hr_high = wd;
        rzpg_pkg::IDX_HR_CREEP_MODE: next_r.hr_cmode = wd;
        rzpg_pkg::IDX_HR_CREEP: next_r.hr_creep = wd;
        rzpg_pkg::IDX_HR_CTRL: next_r.hr_chan = wd[1:0];
        default: ;
      endcase
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_r.rvalid = 1'b1;
      next_r.rdata = {16'h0, rd_word(r, s_axi_araddr[7:2])};
      next_r.rresp = (s_axi_araddr[7:2] > rzpg_pkg::IDX_HR_CTRL) ?
                     2'b10 : 2'b00;
    end else if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end

    // Ramp engine: parameters are latched only on the start edge
    next_r.start_q = start_in;
    next_r.pulse = 1'b0;
    if (start_in && !r.start_q) begin
      f_ini = to_units(r.range_sel, r.initial_f);
      f_st = to_units(r.range_sel, r.steady);
      if (!r.rev_taken) begin
        // Reversible enable holds from the first start until reset
        next_r.rev_taken = 1'b1;
        next_r.rev_live = (r.rev_en == rzpg_pkg::REV_DUAL);
        next_r.rev_mode_sel = (r.rev_en == rzpg_pkg::REV_SINGLE);
      end
      if (r.range_sel > rzpg_pkg::MODE_200HZ_100K) begin
        next_r.err = rzpg_pkg::ERR_MODE;
        next_r.done = 1'b1;
      end else if (f_ini == 16'h0 || f_st == 16'h0) begin
        next_r.err = rzpg_pkg::ERR_FREQ;
        next_r.done = 1'b1;
      end else begin
        next_r.err = rzpg_pkg::ERR_NONE;
        next_r.preset = {r.preset_hi, r.preset_lo};
        next_r.count = 32'h0;
        next_r.f_cur = f_ini;
        next_r.f_tgt = f_st;
        next_r.dir_lvl = r.dir[0];
        next_r.phase = 32'h0;
        next_r.slope_cnt = 32'h0;
        // Clocks per 10 Hz step so the ramp spans the change time
        ramp_t = 32'(r.change_ms) * rzpg_pkg::CYC_PER_MS;
        df = (f_st > f_ini) ? 32'(f_st - f_ini) : 32'(f_ini - f_st);
        next_r.slope_per = (df == 32'h0) ? 32'h1 : ramp_t / df;
        next_r.st = (df == 32'h0) ? RZ_STEADY : RZ_RAMP;
        next_r.trans = (df != 32'h0);
        next_r.active = 1'b1;
        next_r.done = 1'b0;
        next_r.ovf = (r.preset_hi == 16'h0 && r.preset_lo == 16'h0) ?
                     1'b0 : r.ovf;
      end
    end else if (!start_in && r.st != RZ_IDLE) begin
      next_r.st = RZ_IDLE;
      next_r.active = 1'b0;
      next_r.trans = 1'b0;
      next_r.done = 1'b1;
    end else begin
      case (r.st)
        RZ_IDLE: ;
        RZ_RAMP, RZ_STEADY: begin
          // Slope: one 10 Hz step each slope period
          if (r.st == RZ_RAMP) begin
            next_r.slope_cnt = r.slope_cnt + 32'h1;
            if (r.slope_cnt + 32'h1 >= r.slope_per) begin
              next_r.slope_cnt = 32'h0;
              next_r.f_cur = (r.f_tgt > r.f_cur) ? r.f_cur + 16'h1 :
                             r.f_cur - 16'h1;
              if (next_r.f_cur == r.f_tgt) begin
                next_r.st = RZ_STEADY;
                next_r.trans = 1'b0;
              end
            end
          end
          next_r.phase = r.phase + 32'h1;
          if (r.phase + 32'h1 >= (half_per(r.f_cur) << 1)) begin
            next_r.phase = 32'h0;
            next_r.pulse = 1'b1;
            edge_tick = 1'b1;
          end
          if (edge_tick) begin
            next_r.count = r.count + 32'h1;
            if (r.count == 32'hffff_ffff)
              next_r.ovf = 1'b1;
            if (r.count + 32'h1 == r.preset) begin
              next_r.st = RZ_IDLE;
              next_r.active = 1'b0;
              next_r.trans = 1'b0;
              next_r.done = 1'b1;
            end
          end
        end
        default: next_r.st = RZ_IDLE;
      endcase
    end

    // Home return: fast train, creep on deceleration, stop on release
    next_r.hr_q = home_start_in;
    hf = to_units(r.hr_mode, r.hr_high);
    cf = to_units(r.hr_cmode, r.hr_creep);
    case (r.hr)
      HR_IDLE: begin
        if (home_start_in && !r.hr_q && r.hr_chan != 2'b00 &&
            hf != 16'h0 && cf != 16'h0) begin
          next_r.hr = HR_FAST;
          next_r.hr_f = hf;
          next_r.hr_phase = 32'h0;
          next_r.hr_lvl = 1'b0;
        end
      end
      HR_FAST: begin
        if (decel_in) begin
          next_r.hr = HR_CREEP;
          next_r.hr_f = cf;
        end
      end
      HR_CREEP: begin
        if (!decel_in)
          next_r.hr = HR_DONE;
      end
      HR_DONE: begin
        next_r.hr_lvl = 1'b0;
        if (!home_start_in)
          next_r.hr = HR_IDLE;
      end
      default: next_r.hr = HR_IDLE;
    endcase
    if (!home_start_in && r.hr != HR_DONE)
      next_r.hr = HR_IDLE;
    if (next_r.hr == HR_FAST || next_r.hr == HR_CREEP) begin
      // Toggle at each half period gives an exact 50 % duty
      next_r.hr_phase = r.hr_phase + 32'h1;
      if (r.hr_phase + 32'h1 >= half_per(r.hr_f)) begin
        next_r.hr_phase = 32'h0;
        next_r.hr_lvl = ~r.hr_lvl;
      end
    end else begin
      next_r.hr_lvl = 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // State register
  // -----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn)
      r <= '0;
    else
      r <= next_r;
  end

  // -----------------------------------------------------------------
  // Bus handshakes and output pins
  // -----------------------------------------------------------------
  // Ready drops while a word is held so nothing is overwritten
  assign s_axi_awready = !r.aw_hold && !r.bvalid;
  assign s_axi_wready = !r.w_hold && !r.bvalid;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;

  // Pins: home-return channel wins; otherwise ramp or plain output
  always_comb begin
    logic ramp_a;
    logic ramp_b;
    ramp_a = r.pulse && !(r.rev_live && r.dir_lvl);
    ramp_b = r.rev_live ? (r.pulse && r.dir_lvl) :
             r.rev_mode_sel ? r.dir_lvl :
             gpio_out[1];
    if (!r.rev_live && !r.rev_mode_sel)
      ramp_b = gpio_out[1];
    // The last counted pulse stands while the engine is already idle
    pulse_out_a = (r.st != RZ_IDLE || r.pulse) ? ramp_a : gpio_out[0];
    if (!r.rev_live && !r.rev_mode_sel)
      pulse_out_b = ramp_b;
    else
      pulse_out_b = (r.st != RZ_IDLE || r.pulse || r.rev_mode_sel) ?
                    ramp_b : gpio_out[1];
    pulse_out_c = gpio_out[2];
    if (r.hr != HR_IDLE) begin
      case (r.hr_chan)
        2'b01: pulse_out_a = r.hr_lvl;
        2'b10: pulse_out_b = r.hr_lvl;
        2'b11: pulse_out_c = r.hr_lvl;
        default: ;
      endcase
    end
  end

endmodule : rzpg_top

// File: tb/rzpg_asserts.sv
// Checker for the register bus handshake of the pulse block.
// Sees only the top ports; bound into every rzpg_top below.
`timescale 1ns/1ps
module rzpg_asserts #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ----------------------------------------------------------
  // Transfer steps
  // ----------------------------------------------------------
  sequence s_ar_ok;
    s_axi_arvalid && s_axi_arready && s_axi_araddr[ADDR_W-1:2] <= 'h10;
  endsequence
  sequence s_ar_bad;
    s_axi_arvalid && s_axi_arready && s_axi_araddr[ADDR_W-1:2] > 'h10;
  endsequence
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Registers are half-words, so the upper read bits stay zero
  property p_rd_ok;
    s_ar_ok |=> s_axi_rvalid && s_axi_rresp == 2'b00
      && s_axi_rdata[31:16] == 16'h0000;
  endproperty
  a_rd_ok: assert property (p_rd_ok)
    else $error("read answer wrong");
  property p_rd_bad;
    s_ar_bad |=> s_axi_rvalid && s_axi_rresp == 2'b10 && s_axi_rdata == 0;
  endproperty
  a_rd_bad: assert property (p_rd_bad)
    else $error("unmapped read not refused");
  property p_wr_resp;
    s_wr_both |-> ##1 !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp)
    else $error("write answer late or early");
  property p_b_stand;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_stand: assert property (p_b_stand)
    else $error("write answer dropped");
  property p_r_stand;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_stand: assert property (p_r_stand)
    else $error("read answer dropped");
  property p_b_refuse;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_b_refuse: assert property (p_b_refuse)
    else $error("write taken while answer pending");
  property p_r_refuse;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_r_refuse: assert property (p_r_refuse)
    else $error("read taken while answer pending");
  // A lone address must block a second address in the next cycle
  property p_aw_hold;
    s_axi_awvalid && s_axi_awready && !s_axi_wvalid |=> !s_axi_awready;
  endproperty
  a_aw_hold: assert property (p_aw_hold)
    else $error("address taken twice");
  property p_rst_idle;
    $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  a_rst_idle: assert property (p_rst_idle)
    else $error("answer pending after reset");
endmodule : rzpg_asserts

bind rzpg_top rzpg_asserts #(.ADDR_W(ADDR_W)) rzpg_asserts_inst (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// File: tb/rzpg_drive.sv
// Motor drive model: counts steps on each pulse input.
// Assumes step inputs are sampled on the same clock as the block.
`timescale 1ns/1ps
module rzpg_drive (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic step_a,
  input wire logic step_b,
  input wire logic step_c,
  output int cnt_a,
  output int cnt_b,
  output int cnt_c,
  output int per,
  output int hi_c,
  output int lo_c
);
  logic pa, pb, pc;
  int gap, run;
  // Rising edges are steps; gap gives the step period in clocks
  always @(posedge aclk) begin
    gap <= gap + 1;
    run <= run + 1;
    if (step_a && !pa) begin
      cnt_a <= cnt_a + 1;
      per <= gap + 1;
      gap <= 0;
    end
    if (step_b && !pb) begin
      cnt_b <= cnt_b + 1;
      per <= gap + 1;
      gap <= 0;
    end
    // Run lengths on c show the duty of the home-return train
    if (step_c != pc) begin
      if (pc) hi_c <= run + 1;
      else lo_c <= run + 1;
      run <= 0;
      cnt_c <= cnt_c + 32'(step_c);
    end
    pa <= step_a;
    pb <= step_b;
    pc <= step_c;
    if (!aresetn) begin
      cnt_a <= 0;
      cnt_b <= 0;
      cnt_c <= 0;
    end
  end
endmodule : rzpg_drive

// File: tb/rzpg_top_tb.sv
// Self-checking bench for rzpg_top with a drive model on the pulses.
// Assumes a 10 MHz clock and the register map of rzpg_pkg.
`timescale 1ns/1ps
module rzpg_top_tb;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic start, decel, home, pa, pb, pc;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic [2:0] gpio;
  int miscompares, checks, cnt_a, cnt_b, cnt_c, per, hi_c, lo_c, n, k;
  int mdl [0:16];
  int pv [8];
  int rv [4] = '{0, 1, 2, 2};
  int md [4] = '{3, 2, 3, 2};
  int fq [4] = '{1000, 50, 10000, 25};

  rzpg_top #(.ADDR_W(8)) rzpg_top_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .start_in(start), .decel_in(decel),
    .home_start_in(home), .gpio_out(gpio), .pulse_out_a(pa),
    .pulse_out_b(pb), .pulse_out_c(pc));
  rzpg_drive rzpg_drive_inst (.aclk(aclk), .aresetn(aresetn),
    .step_a(pa), .step_b(pb), .step_c(pc), .cnt_a(cnt_a), .cnt_b(cnt_b),
    .cnt_c(cnt_c), .per(per), .hi_c(hi_c), .lo_c(lo_c));

  // 100 ns period clock
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // ----------------------------------------------------------
  // Reporting
  // ----------------------------------------------------------
  task test_done();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task tmo();
    miscompares++;
    $display("Error wait expected answer seen none");
    test_done();
  endtask : tmo

  // ----------------------------------------------------------
  // Bus master; ready is sampled at the negedge, which equals the
  // value at the next rising edge since nothing moves in between
  // ----------------------------------------------------------
  task wr(input logic [5:0] i, input logic [15:0] v);
    logic ta, tw, tb;
    int j;
    @(posedge aclk);
    awaddr <= {i, 2'b00};
    wdata <= {16'h0000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    tb = 1'b0;
    for (j = 0; j < 200 && !tb; j++) begin
      @(negedge aclk);
      ta = awready;
      tw = wready;
      tb = bvalid;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    if (!tb) tmo();
    if (i < 6'h08 || (i > 6'h0b && i < 6'h11)) mdl[i] = v;
  endtask : wr

  task rd(input logic [5:0] i, output logic [31:0] dd,
    output logic [1:0] rr);
    logic ta, tv;
    int j;
    @(posedge aclk);
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    tv = 1'b0;
    for (j = 0; j < 200 && !tv; j++) begin
      @(negedge aclk);
      ta = arready;
      tv = rvalid;
      dd = rdata;
      rr = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    if (!tv) tmo();
  endtask : rd

  task rst();
    @(posedge aclk);
    aresetn <= 1'b0;
    start <= 1'b0;
    decel <= 1'b0;
    home <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    mdl = '{default: 0};
  endtask : rst

  task wdone();
    d = 32'h0;
    for (n = 0; n < 4000 && d[rzpg_pkg::ST_DONE] !== 1'b1; n++)
      rd(rzpg_pkg::IDX_STATUS, d, r);
    if (d[rzpg_pkg::ST_DONE] !== 1'b1) tmo();
  endtask : wdone

  task ld();
    int j;
    for (j = 0; j < 8; j++) wr(6'(j), 16'(pv[j]));
  endtask : ld

  // One burst of four steps at a fixed rate; err is the expected code
  task run(input int rev, input int dir, input int mode, input int f,
    input int err);
    int ca, pr;
    rst();
    pv = '{mode, f, f, 1, rev, dir, 0, 4};
    ld();
    start <= 1'b1;
    wdone();
    pr = 1000000 / (mode == 3 ? f : f * 100);
    ca = (rev == 2 && dir == 1) || err != 0 ? 0 : 4;
    rd(rzpg_pkg::IDX_ERROR, d, r);
    chk("error code", err, d);
    rd(rzpg_pkg::IDX_STATUS, d, r);
    chk("status", 32'h2, d);
    rd(rzpg_pkg::IDX_CUR_LO, d, r);
    if (err == 0) chk("count", 4, d);
    chk("steps a", ca, cnt_a);
    chk("steps b", err != 0 ? 0 : rev == 1 ? dir : 4 - ca,
      cnt_b);
    if (err == 0) chk("period", pr, per);
    if (rev == 1) chk("direction", dir, {31'h0, pb});
    start <= 1'b0;
  endtask : run

  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {start, decel, home} = 3'h0;
    gpio = 3'h0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    miscompares = 0;
    checks = 0;
    void'($urandom(32'h437a34c2));
    // Register reset values, plain outputs, write and read back
    rst();
    for (k = 0; k < 17; k++) begin
      rd(6'(k), d, r);
      chk("reset value", mdl[k], d);
    end
    for (k = 0; k < 3; k++) begin
      gpio <= 3'($urandom);
      repeat (2) @(posedge aclk);
      chk("plain outputs", {29'h0, gpio}, {29'h0, pc, pb, pa});
    end
    gpio <= 3'h0;
    for (k = 0; k < 11; k++) wr(6'(k), 16'($urandom));
    for (k = 0; k < 17; k++) begin
      rd(6'(k), d, r);
      chk("read back", mdl[k], d);
    end
    rd(6'h11, d, r);
    chk("unmapped resp", 32'h2, {30'h0, r});
    // Every direction mode, then both refused settings
    for (k = 0; k < 4; k++)
      run(rv[k], k > 1 ? k - 2 : $urandom % 2, md[k], fq[k], 0);
    run(0, 0, 5, 1000, 1);
    run(0, 0, 3, 5, 2);
    // Ramp from 200 Hz, then release start in mid-burst
    rst();
    pv = '{3, 10000, 20, 1, 0, 0, 1, 0};
    ld();
    start <= 1'b1;
    repeat (3) @(posedge aclk);
    rd(rzpg_pkg::IDX_STATUS, d, r);
    chk("ramp status", 32'h5, d);
    repeat (5000) @(posedge aclk);
    rd(rzpg_pkg::IDX_STATUS, d, r);
    chk("mid ramp", 32'h5, d);
    repeat (7000) @(posedge aclk);
    rd(rzpg_pkg::IDX_STATUS, d, r);
    chk("steady", 32'h1, d);
    start <= 1'b0;
    repeat (3) @(posedge aclk);
    rd(rzpg_pkg::IDX_STATUS, d, r);
    chk("stopped", 32'h2, d);
    rd(rzpg_pkg::IDX_CUR_LO, d, r);
    chk("count low", cnt_a, d);
    rd(rzpg_pkg::IDX_CUR_HI, d, r);
    chk("count high", 0, d);
    n = cnt_a;
    repeat (500) @(posedge aclk);
    chk("no steps", n, cnt_a);
    // Home return on output c: 100 kHz, creep at 10 kHz, then stop
    rst();
    wr(rzpg_pkg::IDX_HR_MODE, 16'h0003);
    wr(rzpg_pkg::IDX_HR_HIGH, 16'h2710);
    wr(rzpg_pkg::IDX_HR_CREEP_MODE, 16'h0003);
    wr(rzpg_pkg::IDX_HR_CREEP, 16'h03e8);
    wr(rzpg_pkg::IDX_HR_CTRL, 16'h0003);
    home <= 1'b1;
    repeat (1000) @(posedge aclk);
    chk("fast high", 1000000 / 10000 / 2, hi_c);
    chk("fast low", 1000000 / 10000 / 2, lo_c);
    decel <= 1'b1;
    repeat (4000) @(posedge aclk);
    chk("creep high", 1000000 / 1000 / 2, hi_c);
    chk("creep low", 1000000 / 1000 / 2, lo_c);
    decel <= 1'b0;
    repeat (20) @(posedge aclk);
    n = cnt_c;
    repeat (3000) @(posedge aclk);
    chk("home stopped", n, cnt_c);
    home <= 1'b0;
    test_done();
  end
endmodule : rzpg_top_tb
